// File: shared/ssp_pkg.sv
/*
 * Shared constants for the synthesizer serial configuration port: frame layout,
 * register file geometry, Wishbone register offsets, field positions and reset values.
 * Assumes a 32-bit classic Wishbone bus with byte addresses and one word per register.
 */
package ssp_pkg;

	// Serial frame layout.
	localparam int unsigned ADDR_W     = 7;
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned FRAME_W    = 24;
	localparam int unsigned REG_COUNT  = 128;
	localparam logic [4:0]  CNT_HDR    = 5'h08;
	localparam logic [4:0]  CNT_FRAME  = 5'h18;
	localparam logic [4:0]  CNT_MAX    = 5'h1F;

	// Register that holds the output pin select, and the bit within it.
	localparam logic [6:0]  SEL_REG_ADDR = 7'h00;
	localparam int unsigned SEL_BIT      = 2;

	// Wishbone register byte offsets.
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_STATUS  = 8'h04;
	localparam logic [7:0]  OFS_RB_ADDR = 8'h08;
	localparam logic [7:0]  OFS_RB_DATA = 8'h0C;
	localparam logic [7:0]  OFS_GOOD    = 8'h10;
	localparam logic [7:0]  OFS_SHORT   = 8'h14;

	// Field positions.
	localparam int unsigned CTRL_EN_BIT     = 0;
	localparam int unsigned STAT_BUSY_BIT   = 0;
	localparam int unsigned STAT_RW_BIT     = 1;
	localparam int unsigned STAT_SEL_BIT    = 2;
	localparam int unsigned STAT_ADDR_LSB   = 8;

	// Reset values.
	localparam logic        CTRL_EN_RST = 1'h1;
	localparam logic [15:0] REG_RST     = 16'h0000;
	localparam logic [15:0] CNT16_RST   = 16'h0000;
	// Pin order is {data, select, clock}; select idles high.
	localparam logic [2:0]  PIN_RST     = 3'h2;

	typedef enum logic [2:0] {
		SSP_IDLE = 3'h1,
		SSP_ADDR = 3'h2,
		SSP_DATA = 3'h4
	} ssp_state_t;

endpackage

// File: shared/ssp_pin_if.sv
/*
 * Synchronised serial pin levels and edge pulses passed from the pin synchroniser
 * to the port core. Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface ssp_pin_if;
	logic sck_lvl;
	logic csn_lvl;
	logic sdi_lvl;
	logic sck_rise;
	logic sck_fall;
	logic csn_fall;
	logic csn_rise;

	modport sync (
		output sck_lvl, csn_lvl, sdi_lvl, sck_rise, sck_fall, csn_fall, csn_rise
	);
	modport core (
		input  sck_lvl, csn_lvl, sdi_lvl, sck_rise, sck_fall, csn_fall, csn_rise
	);
endinterface

// File: rtl/ssp_sync.sv
/*
 * Two-flop synchronisers for the serial clock, select and data pins, and edge detectors for the clock and select only.
 * Assumes the pins are asynchronous to clk_i and change slower than a few clk_i periods.
 */
`timescale 1ns/10ps
module ssp_sync (
	// System
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Raw pins, {data, select, clock}
	input  wire logic [2:0] pins_i,
	// Synchronised view
	ssp_pin_if.sync         pin
);

	logic [2:0] meta_ff;
	logic [2:0] sync_ff;
	logic [2:0] prev_ff;

	// The first stage feeds only the second; edges are taken from stages two and three.
	for (genvar g = 0; g < 3; g++) begin : g_pin
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				meta_ff[g] <= ssp_pkg::PIN_RST[g];
				sync_ff[g] <= ssp_pkg::PIN_RST[g];
				prev_ff[g] <= ssp_pkg::PIN_RST[g];
			end else begin
				meta_ff[g] <= pins_i[g];
				sync_ff[g] <= meta_ff[g];
				prev_ff[g] <= sync_ff[g];
			end
		end
	end

	assign pin.sck_lvl  = sync_ff[0];
	assign pin.csn_lvl  = sync_ff[1];
	assign pin.sdi_lvl  = sync_ff[2];
	assign pin.sck_rise = sync_ff[0] & ~prev_ff[0];
	assign pin.sck_fall = ~sync_ff[0] & prev_ff[0];
	assign pin.csn_fall = ~sync_ff[1] & prev_ff[1];
	assign pin.csn_rise = sync_ff[1] & ~prev_ff[1];

endmodule

// File: rtl/ssp_top.sv
/*
 * Serial configuration port of a frequency synthesizer: 24-bit frames shifted in from
 * a host, a 128 x 16 register file, readback on the multiplexed output pin, and a
 * classic Wishbone slave through which on-chip software watches and steers the port.
 * Assumes the serial pins are asynchronous and much slower than clk_i, and that
 * lock_detect_i comes from logic on clk_i.
 */
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps

module ssp_top (
	// System
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Serial pins
	input  wire logic        serial_clock_i,
	input  wire logic        chip_select_n_i,
	input  wire logic        serial_data_in_i,
	output wire logic        multiplexed_output_pin_o,
	// Synthesizer status
	input  wire logic        lock_detect_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output wire logic [31:0] wb_dat_o,
	output wire logic        wb_ack_o
);

	ssp_pin_if pin_bus ();

	ssp_sync u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pins_i ({serial_data_in_i, chip_select_n_i, serial_clock_i}),
		.pin    (pin_bus)
	);

	ssp_pkg::ssp_state_t state_ff;
	ssp_pkg::ssp_state_t nxt_state;

	logic [4:0]                    cnt_ff;
	logic [ssp_pkg::FRAME_W-2:0]   shift_ff;
	logic                          rd_ff;
	logic [ssp_pkg::ADDR_W-1:0]    addr_ff;
	logic [ssp_pkg::DATA_W-1:0]    rb_shift_ff;
	logic                          rb_bit_ff;
	logic                          pin_ff;
	logic [ssp_pkg::DATA_W-1:0]    regs_ff [ssp_pkg::REG_COUNT];
	logic                          ctrl_en_ff;
	logic [ssp_pkg::ADDR_W-1:0]    rb_addr_ff;
	logic [15:0]                   good_cnt_ff;
	logic [15:0]                   short_cnt_ff;
	logic                          wb_ack_ff;
	logic [31:0]                   wb_dat_ff;

	logic                          in_frame;
	logic                          hdr_done;
	logic [ssp_pkg::ADDR_W-1:0]    hdr_addr;
	logic                          frame_end;
	logic                          full_frame;
	logic                          commit;
	logic                          out_sel;
	logic                          wb_hit;
	logic                          wb_wr;
	logic [7:0]                    wb_ofs;
	logic [31:0]                   rd_word;

	assign in_frame   = (state_ff != ssp_pkg::SSP_IDLE);
	assign hdr_done   = (state_ff == ssp_pkg::SSP_ADDR) && pin_bus.sck_rise &&
	                    (cnt_ff == ssp_pkg::CNT_HDR - 5'h01);
	assign hdr_addr   = {shift_ff[ssp_pkg::ADDR_W-2:0], pin_bus.sdi_lvl};
	assign frame_end  = in_frame && pin_bus.csn_rise;
	assign full_frame = (cnt_ff == ssp_pkg::CNT_FRAME);
	// Overlong frames are treated like short ones: the word boundary is unknown.
	assign commit     = frame_end && (state_ff == ssp_pkg::SSP_DATA) && !rd_ff &&
	                    full_frame;
	assign out_sel    = regs_ff[ssp_pkg::SEL_REG_ADDR][ssp_pkg::SEL_BIT];

	// Frame sequencer. A frame starts only on a falling select, so a select that was
	// already low when the port was enabled is not mistaken for a frame start.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ssp_pkg::SSP_IDLE: begin
				if (pin_bus.csn_fall && ctrl_en_ff) begin
					nxt_state = ssp_pkg::SSP_ADDR;
				end
			end
			ssp_pkg::SSP_ADDR: begin
				if (pin_bus.csn_rise) begin
					nxt_state = ssp_pkg::SSP_IDLE;
				end else if (hdr_done) begin
					nxt_state = ssp_pkg::SSP_DATA;
				end
			end
			ssp_pkg::SSP_DATA: begin
				if (pin_bus.csn_rise) begin
					nxt_state = ssp_pkg::SSP_IDLE;
				end
			end
			default: begin
				nxt_state = ssp_pkg::SSP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ssp_pkg::SSP_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Bit counter saturates so that a very long frame cannot wrap back to a legal count.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= 5'h00;
		end else if (!in_frame) begin
			cnt_ff <= 5'h00;
		end else if (pin_bus.sck_rise && cnt_ff != ssp_pkg::CNT_MAX) begin
			cnt_ff <= cnt_ff + 5'h01;
		end
	end

	// Shifter: header bits always, write data bits only; readback data on the input
	// line is dropped so it can never reach a register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shift_ff <= '0;
		end else if (pin_bus.sck_rise && in_frame) begin
			if (state_ff == ssp_pkg::SSP_ADDR || !rd_ff) begin
				shift_ff <= {shift_ff[ssp_pkg::FRAME_W-3:0], pin_bus.sdi_lvl};
			end
		end
	end

	// The first bit of a frame is the direction flag; the address follows it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_ff   <= 1'h0;
			addr_ff <= '0;
		end else begin
			if (state_ff == ssp_pkg::SSP_ADDR && pin_bus.sck_rise && cnt_ff == 5'h00) begin
				rd_ff <= pin_bus.sdi_lvl;
			end
			if (hdr_done) begin
				addr_ff <= hdr_addr;
			end
		end
	end

	// Readback path. The word is fetched when the header completes and shifted out
	// MSB first, one bit after each falling serial clock, so it is stable for the
	// host's next rising edge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rb_shift_ff <= ssp_pkg::REG_RST;
			rb_bit_ff   <= 1'h0;
		end else if (hdr_done) begin
			rb_shift_ff <= regs_ff[hdr_addr];
			rb_bit_ff   <= 1'h0;
		end else if (state_ff == ssp_pkg::SSP_DATA && rd_ff) begin
			if (pin_bus.sck_fall) begin
				rb_bit_ff   <= rb_shift_ff[ssp_pkg::DATA_W-1];
				rb_shift_ff <= {rb_shift_ff[ssp_pkg::DATA_W-2:0], 1'h0};
			end
		end else begin
			rb_bit_ff <= 1'h0;
		end
	end

	// The pin has no enable: it is a plain push-pull output at all times.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_ff <= 1'h0;
		end else begin
			pin_ff <= out_sel ? lock_detect_i : rb_bit_ff;
		end
	end

	assign multiplexed_output_pin_o = pin_ff;

	// Register file. Only a complete write frame changes it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < ssp_pkg::REG_COUNT; i++) begin
				regs_ff[i] <= ssp_pkg::REG_RST;
			end
		end else if (commit) begin
			regs_ff[addr_ff] <= shift_ff[ssp_pkg::DATA_W-1:0];
		end
	end

	// Frame statistics; they wrap and are never cleared by software.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			good_cnt_ff  <= ssp_pkg::CNT16_RST;
			short_cnt_ff <= ssp_pkg::CNT16_RST;
		end else if (frame_end) begin
			if (full_frame && state_ff == ssp_pkg::SSP_DATA) begin
				good_cnt_ff <= good_cnt_ff + 16'h0001;
			end else begin
				short_cnt_ff <= short_cnt_ff + 16'h0001;
			end
		end
	end

	// Wishbone slave: one wait state, ack for a single cycle, unmapped reads give zero.
	// A write lands at the edge where the master sees ack, so a request that is
	// dropped before its ack can never have changed a register.
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_ff;
	assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_ff;
	assign wb_ofs = {wb_adr_i[7:2], 2'h0};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_en_ff <= ssp_pkg::CTRL_EN_RST;
			rb_addr_ff <= '0;
		end else if (wb_wr && wb_sel_i[0]) begin
			if (wb_ofs == ssp_pkg::OFS_CTRL) begin
				ctrl_en_ff <= wb_dat_i[ssp_pkg::CTRL_EN_BIT];
			end
			if (wb_ofs == ssp_pkg::OFS_RB_ADDR) begin
				rb_addr_ff <= wb_dat_i[ssp_pkg::ADDR_W-1:0];
			end
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		case (wb_ofs)
			ssp_pkg::OFS_CTRL: begin
				rd_word[ssp_pkg::CTRL_EN_BIT] = ctrl_en_ff;
			end
			ssp_pkg::OFS_STATUS: begin
				rd_word[ssp_pkg::STAT_BUSY_BIT] = in_frame;
				rd_word[ssp_pkg::STAT_RW_BIT]   = rd_ff;
				rd_word[ssp_pkg::STAT_SEL_BIT]  = out_sel;
				rd_word[ssp_pkg::STAT_ADDR_LSB +: ssp_pkg::ADDR_W] = addr_ff;
			end
			ssp_pkg::OFS_RB_ADDR: begin
				rd_word[ssp_pkg::ADDR_W-1:0] = rb_addr_ff;
			end
			ssp_pkg::OFS_RB_DATA: begin
				rd_word[ssp_pkg::DATA_W-1:0] = regs_ff[rb_addr_ff];
			end
			ssp_pkg::OFS_GOOD: begin
				rd_word[15:0] = good_cnt_ff;
			end
			ssp_pkg::OFS_SHORT: begin
				rd_word[15:0] = short_cnt_ff;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_ff <= 1'h0;
			wb_dat_ff <= 32'h0000_0000;
		end else begin
			wb_ack_ff <= wb_hit;
			if (wb_hit && !wb_we_i) begin
				wb_dat_ff <= rd_word;
			end
		end
	end

	assign wb_ack_o = wb_ack_ff;
	assign wb_dat_o = wb_dat_ff;

endmodule

// File: tb/ssp_top_assertions.sv
/* Port checker for ssp_top, bound at the foot of this file.
   Assumes the bench moves the serial pins only at clk_i edges. */
`timescale 1ns/10ps
module ssp_top_assertions (
	// System and serial pins
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        serial_clock_i,
	input wire logic        chip_select_n_i,
	input wire logic        serial_data_in_i,
	input wire logic        multiplexed_output_pin_o,
	input wire logic        lock_detect_i,
	// Wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	logic        sck_ff, csn_ff, rd_ff, sel_ff, rise;
	logic [4:0]  cnt_ff;
	logic [23:0] sh_ff;
	logic [3:0]  fall_ff;
	assign rise = serial_clock_i && !sck_ff && !chip_select_n_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge clk_i) begin
		sck_ff <= serial_clock_i;
		csn_ff <= chip_select_n_i;
		if (rise) begin
			sh_ff <= {sh_ff[22:0], serial_data_in_i};
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || chip_select_n_i) begin
			cnt_ff <= 5'h00;
		end else if (rise) begin
			cnt_ff <= cnt_ff + 5'h01;
		end
		if (rst_i) begin
			rd_ff <= 1'b0;
		end else if (rise && cnt_ff == 5'h00) begin
			rd_ff <= serial_data_in_i;
		end
	end
	// The checker keeps its own copy of the pin select so it never trusts the design's.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_ff <= 1'b0;
		end else if (chip_select_n_i && !csn_ff && cnt_ff == 5'h18 && sh_ff[23:16] == 8'h00) begin
			sel_ff <= sh_ff[ssp_pkg::SEL_BIT];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || (sck_ff && !serial_clock_i)) begin
			fall_ff <= 4'h0;
		end else if (fall_ff != 4'hF) begin
			fall_ff <= fall_ff + 4'h1;
		end
	end
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause;
		$rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_hold;
		!(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o);
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without read");
	property p_pin_addr;
		rd_ff && cnt_ff >= 5'h02 && cnt_ff <= 5'h07 && !chip_select_n_i && !lock_detect_i
			&& !$past(lock_detect_i) |-> !multiplexed_output_pin_o;
	endproperty
	a_pin_addr: assert property (p_pin_addr) else $error("pin high in address part");
	property p_pin_edge;
		rd_ff && cnt_ff >= 5'h08 && !chip_select_n_i && $changed(multiplexed_output_pin_o)
			|-> fall_ff >= 4'h2 && fall_ff <= 4'h7;
	endproperty
	a_pin_edge: assert property (p_pin_edge) else $error("readback bit off its edge");
	property p_mux_lock;
		$rose(lock_detect_i) && sel_ff && chip_select_n_i |-> ##[1:2] multiplexed_output_pin_o;
	endproperty
	a_mux_lock: assert property (p_mux_lock) else $error("lock not on pin");
	property p_mux_rb;
		$rose(lock_detect_i) && !sel_ff && chip_select_n_i |=> (!multiplexed_output_pin_o) [*3];
	endproperty
	a_mux_rb: assert property (p_mux_rb) else $error("lock leaked to pin");
endmodule

bind ssp_top ssp_top_assertions chk (
	.clk_i                    (clk_i),
	.rst_i                    (rst_i),
	.serial_clock_i           (serial_clock_i),
	.chip_select_n_i          (chip_select_n_i),
	.serial_data_in_i         (serial_data_in_i),
	.multiplexed_output_pin_o (multiplexed_output_pin_o),
	.lock_detect_i            (lock_detect_i),
	.wb_cyc_i                 (wb_cyc_i),
	.wb_stb_i                 (wb_stb_i),
	.wb_we_i                  (wb_we_i),
	.wb_dat_o                 (wb_dat_o),
	.wb_ack_o                 (wb_ack_o)
);

// File: tb/ssp_host_model.sv
/* Host model that frames bits onto the serial pins of the port.
   Assumes clk_i is the system clock; the link clock averages 125 ns from it. */
`timescale 1ns/10ps
module ssp_host_model (
	// System
	input  wire logic clk_i,
	// Serial pins
	output logic      sck_o,
	output logic      csn_o,
	output logic      sdi_o,
	input  wire logic pin_i
);
	initial begin
		sck_o = 1'b0;
		csn_o = 1'b1;
		sdi_o = 1'b0;
	end
	// Sends the first n bits of w; with skip set the select stays high.
	task automatic xfer(input logic [23:0] w, input int n, input logic skip,
		output logic [15:0] rb);
		rb = 16'h0000;
		@(posedge clk_i);
		csn_o <= skip;
		for (int i = 0; i < n; i++) begin
			repeat (3) @(posedge clk_i);
			sdi_o <= w[23 - i];
			repeat (4) @(posedge clk_i);
			sck_o <= 1'b1;
			if (i >= 8) begin
				rb = {rb[14:0], pin_i};
			end
			repeat (5 + i % 2) @(posedge clk_i);
			sck_o <= 1'b0;
		end
		repeat (6) @(posedge clk_i);
		csn_o <= 1'b1;
		// A released data line must not keep showing the last bit.
		sdi_o <= ~sdi_o;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

// File: tb/ssp_top_tb.sv
/* Self-checking bench for ssp_top: Wishbone master tasks and a host model on the pins.
   Assumes ssp_top answers each Wishbone request within a few cycles; every wait is bounded. */
`timescale 1ns/10ps
module ssp_top_tb;
	logic        clk_i, rst_i, lock_detect_i, sck, csn, serial_data_in, pin;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [15:0] rb;
	int          err_count, num_checks;

	ssp_top dut (.clk_i(clk_i), .rst_i(rst_i), .serial_clock_i(sck), .chip_select_n_i(csn),
		.serial_data_in_i(serial_data_in), .multiplexed_output_pin_o(pin), .lock_detect_i(lock_detect_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
	ssp_host_model host (.clk_i(clk_i), .sck_o(sck), .csn_o(csn), .sdi_o(serial_data_in), .pin_i(pin));

	task automatic summarize();
		if (err_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 20) begin
			err_count++;
			summarize();
		end
	endtask
	task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string name);
		logic [31:0] q;
		wb(1'b0, adr, 32'h0000_0000, q);
		check(name, q, exp);
	endtask
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, adr, d, q);
	endtask

	task automatic t_reset();
		rd(ssp_pkg::OFS_CTRL, 32'h0000_0001, "ctrl");
		rd(ssp_pkg::OFS_STATUS, 32'h0000_0000, "status");
		wr(8'h18, 32'hFFFF_FFFF);
		rd(8'h18, 32'h0000_0000, "unmapped");
		rd(ssp_pkg::OFS_RB_DATA, 32'h0000_0000, "reg0");
	endtask
	task automatic chk_reg(input logic [6:0] a, input logic [15:0] exp, input string name);
		wr(ssp_pkg::OFS_RB_ADDR, {25'h000_0000, a});
		rd(ssp_pkg::OFS_RB_DATA, {16'h0000, exp}, name);
	endtask
	task automatic t_write_read();
		host.xfer({1'b0, 7'h05, 16'hA5C3}, 24, 1'b0, rb);
		wr(ssp_pkg::OFS_RB_ADDR, 32'h0000_0005);
		rd(ssp_pkg::OFS_RB_DATA, 32'h0000_A5C3, "reg5");
		host.xfer({1'b1, 7'h05, 16'hFFFF}, 24, 1'b0, rb);
		check("readback", {16'h0000, rb}, 32'h0000_A5C3);
		rd(ssp_pkg::OFS_STATUS, 32'h0000_0502, "status after read");
		rd(ssp_pkg::OFS_RB_DATA, 32'h0000_A5C3, "reg5 after read");
		rd(ssp_pkg::OFS_GOOD, 32'h0000_0002, "good");
	endtask
	task automatic t_refused();
		host.xfer({1'b0, 7'h05, 16'h1234}, 23, 1'b0, rb);
		rd(ssp_pkg::OFS_SHORT, 32'h0000_0001, "short");
		host.xfer({1'b0, 7'h05, 16'h1234}, 24, 1'b1, rb);
		rd(ssp_pkg::OFS_RB_DATA, 32'h0000_A5C3, "reg5 kept");
		rd(ssp_pkg::OFS_GOOD, 32'h0000_0002, "good kept");
		// A frame that starts while the port is disabled must leave no trace at all.
		wr(ssp_pkg::OFS_CTRL, 32'h0000_0000);
		rd(ssp_pkg::OFS_CTRL, 32'h0000_0000, "ctrl off");
		host.xfer({1'b0, 7'h05, 16'h1234}, 24, 1'b0, rb);
		rd(ssp_pkg::OFS_RB_DATA, 32'h0000_A5C3, "reg5 while off");
		rd(ssp_pkg::OFS_GOOD, 32'h0000_0002, "good while off");
		rd(ssp_pkg::OFS_SHORT, 32'h0000_0001, "short while off");
		wr(ssp_pkg::OFS_CTRL, 32'h0000_0001);
		rd(ssp_pkg::OFS_CTRL, 32'h0000_0001, "ctrl on");
	endtask
	task automatic t_mux();
		lock_detect_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		check("pin sel0", pin, 1'b0);
		lock_detect_i <= 1'b0;
		host.xfer({1'b0, 7'h00, 16'h0004}, 24, 1'b0, rb);
		lock_detect_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		check("pin sel1", pin, 1'b1);
		lock_detect_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check("pin sel1 low", pin, 1'b0);
		host.xfer(24'h00_0000, 24, 1'b0, rb);
	endtask
	// Legal settings at the ends of their ranges, each to a register of its own.
	task automatic t_config();
		host.xfer({1'b0, 7'h10, 16'h0001}, 24, 1'b0, rb);
		host.xfer({1'b0, 7'h11, 16'h0080}, 24, 1'b0, rb);
		host.xfer({1'b0, 7'h12, 16'h00FF}, 24, 1'b0, rb);
		host.xfer({1'b0, 7'h13, 16'h001C}, 24, 1'b0, rb);
		host.xfer({1'b0, 7'h14, 16'hFFFF}, 24, 1'b0, rb);
		host.xfer({1'b0, 7'h15, 16'h0004}, 24, 1'b0, rb);
		host.xfer({1'b0, 7'h16, 16'h00C0}, 24, 1'b0, rb);
		chk_reg(7'h10, 16'h0001, "doubler");
		chk_reg(7'h11, 16'h0080, "first divider");
		chk_reg(7'h12, 16'h00FF, "second divider");
		chk_reg(7'h13, 16'h001C, "feedback divider");
		chk_reg(7'h14, 16'hFFFF, "denominator");
		chk_reg(7'h15, 16'h0004, "order");
		chk_reg(7'h16, 16'h00C0, "channel divider");
		host.xfer({1'b1, 7'h16, 16'h0000}, 24, 1'b0, rb);
		check("divider readback", {16'h0000, rb}, 32'h0000_00C0);
		rd(ssp_pkg::OFS_GOOD, 32'h0000_000C, "good after config");
	endtask
	// A second reset in mid-run must bring back the reset values of both counters, the readback address, the control, register 0x16 and the pin.
	task automatic t_reset_again();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(ssp_pkg::OFS_GOOD, 32'h0000_0000, "good after reset");
		rd(ssp_pkg::OFS_SHORT, 32'h0000_0000, "short after reset");
		rd(ssp_pkg::OFS_RB_ADDR, 32'h0000_0000, "rb addr after reset");
		rd(ssp_pkg::OFS_CTRL, 32'h0000_0001, "ctrl after reset");
		chk_reg(7'h16, 16'h0000, "divider after reset");
		check("pin after reset", pin, 1'b0);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		lock_detect_i = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0000_0000;
		err_count = 0;
		num_checks = 0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_reset();
		t_write_read();
		t_refused();
		t_mux();
		t_config();
		t_reset_again();
		summarize();
	end
endmodule
